// [cpu_bus_model.sv]
// CPU model that issues accesses on the sequencer register bus
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic mclk_i, // System clock
  output logic bus_valid_o, // Request strobe
  output flash_seq_pkg::bus_req_t bus_o, // Request fields
  input wire logic bus_ack_i, // Access complete
  input wire logic [31:0] bus_rdata_i, // Read data
  input wire logic cmd_valid_i, // Command pulse to control unit
  input wire logic [15:0] cmd_data_i // Command word to control unit
);
  import flash_seq_pkg::*;
  int gap = 0;
  initial begin
    bus_valid_o = 1'b0;
    bus_o = '0;
  end
  // ------------------------------------------------------------
  // One access, launched and ended at falling edges
  // ------------------------------------------------------------
  task automatic xfer(input logic we, input size_t sz,
                      input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output int lat,
                      output logic cv, output logic [15:0] cd);
    repeat (gap + 1) @(negedge mclk_i);
    bus_valid_o = 1'b1;
    bus_o = '{we: we, size: sz, addr: addr, wdata: wdata};
    lat = 0;
    do begin
      @(negedge mclk_i);
      lat++;
    end while (bus_ack_i !== 1'b1 && lat < 20);
    rdata = bus_rdata_i;
    cv = cmd_valid_i;
    cd = cmd_data_i;
    // Request stands past the rising edge that sees the answer
    @(negedge mclk_i);
    bus_valid_o = 1'b0;
    // Released lines flip so a stale request can never look valid
    bus_o.addr = ~addr;
    bus_o.wdata = ~wdata;
  endtask : xfer
endmodule : cpu_bus_model

// [flash_program_erase_sequencer_front.sv]
// Command interface front end of the flash program/erase sequencer
//
// Overview of operation
// RQ1: Command interface takes bus commands and steers the flash control unit.
// RQ2: Four-byte command window at 007E0000h is decoded.
// RQ3: 128-byte option area FE7F5D00h to FE7F5D7Fh is provided.
// RQ4: Sequencer register accesses finish in two to four clock cycles.
// RQ5: Protect register accesses finish in four to five cycles, eight bits.
// RQ6: End address, blank check and program start registers only on large flash.
// RQ7: Program, erase, blank check allowed only while the enable field holds 01.
// RQ8: Protect register bits seven to two read zero; software writes zero.
// RQ9: Protect register returns to zero on every reset and standby entry.
// RQ10: Software leaves undiscussed registers at their reset values.
// RQ11: Access violation locks commands until status clear or forced stop.
// RQ12: Ready interrupt pulses on command completion when enabled.
// RQ13: Writes into the command window become commands, not stored memory.
`timescale 1ns/1ps
module flash_program_erase_sequencer_front #(
  parameter bit LARGE_FLASH = 1'b1,
  parameter logic [3:0] REG_WAIT = flash_seq_pkg::REG_ACC_CYC,
  parameter logic [3:0] PROT_WAIT = flash_seq_pkg::PROT_ACC_CYC
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Synchronous reset, all reset sources
  input wire logic bus_valid_i, // Request strobe, held until after the acknowledge
  input wire flash_seq_pkg::bus_req_t bus_i, // Request fields
  output logic bus_ack_o, // Access complete
  output logic [31:0] bus_rdata_o, // Read data, right-justified
  output logic cmd_valid_o, // Command pulse to control unit
  output logic [15:0] cmd_data_o, // Command code or operand
  output logic pe_enable_o, // Program/erase permitted
  output logic blank_enable_o, // Blank check permitted
  output logic [31:0] start_addr_o, // Command start address
  output logic [31:0] end_addr_o, // Command end address
  output logic [15:0] mode_entry_o, // P/E mode entry value
  input wire logic [31:0] fcu_status_i, // Control unit status word
  input wire logic [7:0] blank_result_i, // Blank check result
  input wire logic [31:0] prog_addr_i, // Programming start address
  input wire logic [31:0] window_mon_i, // Access window monitor
  input wire logic fcu_done_i, // Command completed pulse
  input wire logic code_area_violation_flag_i, // Code area violation
  input wire logic data_area_violation_flag_i, // Data area violation
  input wire logic standby_entry_i, // Standby entry pulse
  output logic ready_interrupt_o, // Ready interrupt pulse
  output logic command_lock_flag_o // Command-locked state
);
  import flash_seq_pkg::*;

  seq_state_t r;
  seq_state_t n;

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (REG_WAIT < 4'h2 || REG_WAIT > 4'h4) begin : g_bad_reg
    $error("REG_WAIT must lie in 2..4");
  end
  if (PROT_WAIT < 4'h4 || PROT_WAIT > 4'h5) begin : g_bad_prot
    $error("PROT_WAIT must lie in 4..5");
  end

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  logic take;
  logic last_cyc;
  logic in_win;
  logic in_opt;
  logic clr_code;
  logic clr_cmd;
  logic rdy_cause;
  logic [4:0] opt_idx;
  logic [4:0] opt_shift;

  assign take = (r.ph == PH_IDLE) && bus_valid_i;
  assign last_cyc = (r.ph == PH_WAIT) && (r.cnt == 4'h1);
  // RQ2 window decode
  assign in_win = (r.req.addr >= CMD_WIN_BASE) &&
                  (r.req.addr <= CMD_WIN_LAST);
  // RQ3 option area decode
  assign in_opt = (r.req.addr >= OPT_BASE) && (r.req.addr <= OPT_LAST);
  assign clr_code = (r.req.wdata[7:0] == STATUS_CLEAR_CODE) ||
                    (r.req.wdata[7:0] == FORCED_STOP_CODE);
  assign clr_cmd = last_cyc && r.req.we && in_win && clr_code;
  assign rdy_cause = fcu_done_i && r.rdy_ie;
  assign opt_idx = r.req.addr[6:2];
  assign opt_shift = {r.req.addr[1:0], 3'b000};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] w;
    rd = 32'h0000_0000;
    w = r.req.wdata;
    n = r;
    n.cmd_v = 1'b0;
    // RQ12 ready pulse
    n.rdy_irq = rdy_cause;
    unique case (r.ph)
      PH_IDLE: begin
        if (bus_valid_i) begin
          n.req = bus_i;
          n.ph = PH_WAIT;
          // RQ4 RQ5 access timing
          n.cnt = (bus_i.addr == PROT_ADDR) ? PROT_WAIT - 4'h1 :
                                              REG_WAIT - 4'h1;
        end
      end
      PH_WAIT: begin
        if (r.cnt == 4'h1) begin
          n.ph = PH_DONE;
          if (in_win) begin
            // RQ13 forward to control unit
            if (r.req.we && (!r.lock || clr_code)) begin
              n.cmd_v = 1'b1;
              n.cmd_d = w[15:0];
              n.cmd_last = w[15:0];
            end
            // RQ11 unlock on clear or stop
            if (r.req.we && clr_code) begin
              n.code_area_violation_flag = 1'b0;
              n.data_area_violation_flag = 1'b0;
              n.lock = 1'b0;
              n.cf_seen = 1'b0;
              n.df_seen = 1'b0;
            end
          end else if (in_opt) begin
            rd = r.opt[opt_idx] >> opt_shift;
            if (r.req.we) begin
              for (int b = 0; b < 4; b++) begin
                if (r.req.size == SZ32) begin
                  n.opt[opt_idx][8*b +: 8] = w[8*b +: 8];
                end else if (r.req.size == SZ16 &&
                             r.req.addr[1] == b[1]) begin
                  n.opt[opt_idx][8*b +: 8] = w[8*b[0] +: 8];
                end else if (r.req.size == SZ8 &&
                             r.req.addr[1:0] == b[1:0]) begin
                  n.opt[opt_idx][8*b +: 8] = w[7:0];
                end
              end
            end
          end else begin
            unique case (r.req.addr)
              PROT_ADDR: begin
                // RQ8 upper bits read zero
                rd = {30'h0, r.prot};
                if (r.req.we) n.prot = w[1:0];
              end
              ACC_STAT_ADDR: begin
                rd[CODE_AREA_VIOLATION_FLAG_BIT] = r.code_area_violation_flag;
                rd[LOCK_BIT] = r.lock;
                rd[DATA_AREA_VIOLATION_FLAG_BIT] = r.data_area_violation_flag && LARGE_FLASH;
                if (r.req.we) begin
                  if (!w[CODE_AREA_VIOLATION_FLAG_BIT] && r.cf_seen) begin
                    n.code_area_violation_flag = 1'b0;
                    n.cf_seen = 1'b0;
                  end
                  if (!w[DATA_AREA_VIOLATION_FLAG_BIT] && r.df_seen) begin
                    n.data_area_violation_flag = 1'b0;
                    n.df_seen = 1'b0;
                  end
                end else begin
                  // Clear is armed only once a 1 was seen
                  n.cf_seen = r.cf_seen || r.code_area_violation_flag;
                  n.df_seen = r.df_seen || r.data_area_violation_flag;
                end
              end
              ERR_IE_ADDR: begin
                rd[7:0] = r.err_ie;
                if (!LARGE_FLASH) begin
                  rd[DATA_AREA_VIOLATION_FLAG_BIT] = 1'b1;
                end
                if (r.req.we) n.err_ie = w[7:0] & ERR_IE_MASK;
              end
              RDY_IE_ADDR: begin
                rd[RDY_IE_BIT] = r.rdy_ie;
                if (r.req.we) n.rdy_ie = w[RDY_IE_BIT];
              end
              START_ADDR_ADDR: begin
                rd = r.saddr;
                if (r.req.we) n.saddr = w;
              end
              // RQ6 large-flash-only registers
              END_ADDR_ADDR: begin
                if (LARGE_FLASH) begin
                  rd = r.eaddr;
                  if (r.req.we) n.eaddr = w;
                end
              end
              BC_CTRL_ADDR: begin
                if (LARGE_FLASH) begin
                  rd[7:0] = r.bccnt;
                  if (r.req.we) n.bccnt = w[7:0];
                end
              end
              BC_RES_ADDR: begin
                if (LARGE_FLASH) rd[7:0] = blank_result_i;
              end
              PSADDR_ADDR: begin
                if (LARGE_FLASH) rd = prog_addr_i;
              end
              SEQ_STAT_ADDR: begin
                rd = fcu_status_i;
              end
              ENTRY_ADDR: begin
                rd[15:0] = r.entry;
                if (r.req.we) n.entry = w[15:0];
              end
              SUINIT_ADDR: begin
                rd[15:0] = r.suinit;
                if (r.req.we) n.suinit = w[15:0];
              end
              CMD_CODE_ADDR: begin
                rd[15:0] = r.cmd_last;
              end
              WIN_MON_ADDR: begin
                rd = window_mon_i;
              end
              PSW_ADDR: begin
                rd[15:0] = r.cpsr;
                if (r.req.we) n.cpsr = w[15:0];
              end
              PCK_ADDR: begin
                rd[15:0] = r.pckar;
                if (r.req.we) n.pckar = w[15:0];
              end
              SUACR_ADDR: begin
                rd[15:0] = r.suacr;
                if (r.req.we) n.suacr = w[15:0];
              end
              default: rd = 32'h0000_0000;
            endcase
          end
          n.rdata = rd;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      PH_DONE: n.ph = PH_IDLE;
      default: n.ph = PH_IDLE;
    endcase
    // RQ11 violation sets win over clears
    if (code_area_violation_flag_i) begin
      n.code_area_violation_flag = 1'b1;
      n.lock = 1'b1;
    end
    if (data_area_violation_flag_i && LARGE_FLASH) begin
      n.data_area_violation_flag = 1'b1;
      n.lock = 1'b1;
    end
    // RQ9 standby returns protect field to zero
    if (standby_entry_i) n.prot = PROT_RST;
  end

  // RQ9 reset covers every reset source
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus_ack_o = (r.ph == PH_DONE);
  assign bus_rdata_o = r.rdata;
  // RQ1 steering of the control unit
  assign cmd_valid_o = r.cmd_v;
  assign cmd_data_o = r.cmd_d;
  // RQ7 only code 01 enables
  assign pe_enable_o = (r.prot == PE_ENABLE_CODE);
  assign blank_enable_o = LARGE_FLASH && (r.prot == PE_ENABLE_CODE);
  assign start_addr_o = r.saddr;
  assign end_addr_o = r.eaddr;
  assign mode_entry_o = r.entry;
  assign ready_interrupt_o = r.rdy_irq;
  assign command_lock_flag_o = r.lock;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_prot_lat;
    @(posedge mclk_i) disable iff (rst_i)
    take && (bus_i.addr == PROT_ADDR) |=> !bus_ack_o [*3] ##1 bus_ack_o;
  endproperty
  a_prot_lat: assert property (p_prot_lat) // RQ5
    else $error("protect access not answered in four cycles");

  property p_reg_lat;
    @(posedge mclk_i) disable iff (rst_i)
    take && (bus_i.addr[31:8] == REG_PAGE) |=> !bus_ack_o ##1 bus_ack_o;
  endproperty
  a_reg_lat: assert property (p_reg_lat) // RQ4
    else $error("register access not answered in two cycles");

  property p_pe_code;
    @(posedge mclk_i) disable iff (rst_i)
    bus_ack_o && r.req.we && (r.req.addr == PROT_ADDR) &&
      !$past(standby_entry_i) |->
      (pe_enable_o == (r.req.wdata[1:0] == 2'b01));
  endproperty
  a_pe_code: assert property (p_pe_code) // RQ7
    else $error("enable output does not follow written code");

  property p_prot_rsvd;
    @(posedge mclk_i) disable iff (rst_i)
    bus_ack_o && !r.req.we && (r.req.addr == PROT_ADDR) |->
      (bus_rdata_o[31:2] == 30'h0);
  endproperty
  a_prot_rsvd: assert property (p_prot_rsvd) // RQ8
    else $error("protect reserved bits not zero");

  property p_standby;
    @(posedge mclk_i) disable iff (rst_i)
    standby_entry_i |=> !pe_enable_o && !blank_enable_o;
  endproperty
  a_standby: assert property (p_standby) // RQ9
    else $error("standby entry left programming enabled");

  property p_lock_set;
    @(posedge mclk_i) disable iff (rst_i)
    code_area_violation_flag_i |=> command_lock_flag_o;
  endproperty
  a_lock_set: assert property (p_lock_set) // RQ11
    else $error("violation did not lock commands");

  property p_lock_hold;
    @(posedge mclk_i) disable iff (rst_i)
    command_lock_flag_o && !clr_cmd |=> command_lock_flag_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold) // RQ11
    else $error("lock released without clear command");

  property p_rdy;
    @(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> (ready_interrupt_o == $past(rdy_cause));
  endproperty
  a_rdy: assert property (p_rdy) // RQ12
    else $error("ready interrupt does not match completion");

  property p_win_fwd;
    @(posedge mclk_i) disable iff (rst_i)
    bus_ack_o && r.req.we && in_win && !$past(r.lock) |-> cmd_valid_o &&
      (cmd_data_o == r.req.wdata[15:0]);
  endproperty
  a_win_fwd: assert property (p_win_fwd) // RQ13
    else $error("window write not forwarded as command");

  property p_small_var;
    @(posedge mclk_i) disable iff (rst_i)
    bus_ack_o && !LARGE_FLASH && (r.req.addr == END_ADDR_ADDR) |->
      (bus_rdata_o == 32'h0000_0000);
  endproperty
  a_small_var: assert property (p_small_var) // RQ6
    else $error("absent register returned data");

endmodule : flash_program_erase_sequencer_front

// [flash_program_erase_sequencer_front_tb.sv]
// Self-checking bench for the flash sequencer front end
`timescale 1ns/1ps
module flash_program_erase_sequencer_front_tb;
  import flash_seq_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_valid_i;
  bus_req_t bus_i;
  logic bus_ack_o, cmd_valid_o, pe_enable_o, blank_enable_o;
  logic ready_interrupt_o, command_lock_flag_o;
  logic [31:0] bus_rdata_o, start_addr_o, end_addr_o;
  logic [15:0] cmd_data_o, mode_entry_o;
  logic [31:0] fcu_status_i = '0, prog_addr_i = '0, window_mon_i = '0;
  logic [7:0] blank_result_i = '0;
  logic fcu_done_i = 1'b0, standby_entry_i = 1'b0;
  logic code_area_violation_flag_i = 1'b0, data_area_violation_flag_i = 1'b0;
  logic [31:0] seed = 32'h0000_004b;
  logic [31:0] rd, d, a;
  logic [15:0] cd;
  logic cv;
  logic blank_en_s;
  logic [31:0] end_addr_s;
  int lat, num_errors = 0, n_checks = 0, cyc = 0;
  logic [31:0] zero_a [13] = '{PROT_ADDR, ACC_STAT_ADDR, ERR_IE_ADDR,
    RDY_IE_ADDR, START_ADDR_ADDR, END_ADDR_ADDR, ENTRY_ADDR, SUINIT_ADDR,
    CMD_CODE_ADDR, BC_CTRL_ADDR, PSW_ADDR, PCK_ADDR, SUACR_ADDR};
  logic [31:0] rw_a [5] = '{START_ADDR_ADDR, END_ADDR_ADDR, RDY_IE_ADDR,
    ERR_IE_ADDR, ENTRY_ADDR};
  logic [31:0] rw_m [5] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001,
    {24'h0, ERR_IE_MASK}, 32'h0000_ffff};

  always #10 mclk_i = ~mclk_i;

  flash_program_erase_sequencer_front dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus_valid_i(bus_valid_i), .bus_i(bus_i), .bus_ack_o(bus_ack_o),
    .bus_rdata_o(bus_rdata_o), .cmd_valid_o(cmd_valid_o),
    .cmd_data_o(cmd_data_o), .pe_enable_o(pe_enable_o),
    .blank_enable_o(blank_enable_o), .start_addr_o(start_addr_o),
    .end_addr_o(end_addr_o), .mode_entry_o(mode_entry_o),
    .fcu_status_i(fcu_status_i), .blank_result_i(blank_result_i),
    .prog_addr_i(prog_addr_i), .window_mon_i(window_mon_i),
    .fcu_done_i(fcu_done_i),
    .code_area_violation_flag_i(code_area_violation_flag_i),
    .data_area_violation_flag_i(data_area_violation_flag_i),
    .standby_entry_i(standby_entry_i),
    .ready_interrupt_o(ready_interrupt_o),
    .command_lock_flag_o(command_lock_flag_o));

  cpu_bus_model cpu (.mclk_i(mclk_i), .bus_valid_o(bus_valid_i),
    .bus_o(bus_i), .bus_ack_i(bus_ack_o), .bus_rdata_i(bus_rdata_o),
    .cmd_valid_i(cmd_valid_o), .cmd_data_i(cmd_data_o));

  // Small-flash variant shares the bus to exercise the absent registers
  flash_program_erase_sequencer_front #(.LARGE_FLASH(1'b0)) dut_small (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus_valid_i(bus_valid_i), .bus_i(bus_i),
    .bus_ack_o(), .bus_rdata_o(), .cmd_valid_o(), .cmd_data_o(),
    .pe_enable_o(), .blank_enable_o(blank_en_s), .start_addr_o(),
    .end_addr_o(end_addr_s), .mode_entry_o(),
    .fcu_status_i(fcu_status_i), .blank_result_i(blank_result_i),
    .prog_addr_i(prog_addr_i), .window_mon_i(window_mon_i),
    .fcu_done_i(fcu_done_i),
    .code_area_violation_flag_i(code_area_violation_flag_i),
    .data_area_violation_flag_i(data_area_violation_flag_i),
    .standby_entry_i(standby_entry_i), .ready_interrupt_o(),
    .command_lock_flag_o());

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic we, input logic [31:0] ad,
                     input logic [31:0] wd, input size_t sz);
    cpu.gap = int'(rnd() % 3);
    cpu.xfer(we, sz, ad, wd, rd, lat, cv, cd);
    chk(32'(lat), 32'(ad == PROT_ADDR ? PROT_ACC_CYC : REG_ACC_CYC));
  endtask : acc

  task automatic rdc(input logic [31:0] ad, input logic [31:0] exp);
    acc(1'b0, ad, rnd(), SZ32);
    chk(rd, exp);
  endtask : rdc

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Ceiling far above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    foreach (zero_a[i]) rdc(zero_a[i], 32'h0);
    rdc(OPT_BASE, 32'h0);
    $display("test done: reset values");
    foreach (rw_a[i]) begin
      d = rnd() & rw_m[i];
      acc(1'b1, rw_a[i], d, SZ32);
      rdc(rw_a[i], d);
      if (i == 0) chk(start_addr_o, d);
      if (i == 1) chk(end_addr_o, d);
      if (i == 1) chk(end_addr_s, 32'h0);
      if (i == 4) chk({16'h0, mode_entry_o}, d);
    end
    @(negedge mclk_i);
    fcu_status_i = rnd();
    blank_result_i = 8'(rnd());
    prog_addr_i = rnd();
    window_mon_i = rnd();
    rdc(SEQ_STAT_ADDR, fcu_status_i);
    rdc(BC_RES_ADDR, {24'h0, blank_result_i});
    rdc(PSADDR_ADDR, prog_addr_i);
    rdc(WIN_MON_ADDR, window_mon_i);
    $display("test done: register access");
    // Software keeps reserved bits zero; reads must show them zero too
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, PROT_ADDR, 32'(k), SZ8);
      acc(1'b0, PROT_ADDR, rnd(), SZ8);
      chk(rd, 32'(k));
      chk({31'h0, blank_en_s}, 32'h0);
      chk({31'h0, pe_enable_o}, {31'h0, k == 1});
      chk({31'h0, blank_enable_o}, {31'h0, k == 1});
    end
    acc(1'b1, PROT_ADDR, 32'h1, SZ8);
    pulse(standby_entry_i);
    chk({31'h0, pe_enable_o}, 32'h0);
    rdc(PROT_ADDR, 32'h0);
    acc(1'b1, PROT_ADDR, 32'h1, SZ8);
    pulse(rst_i);
    chk({31'h0, pe_enable_o}, 32'h0);
    rdc(PROT_ADDR, 32'h0);
    $display("test done: protect register");
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      acc(1'b1, CMD_WIN_BASE + 32'(i), d, SZ16);
      chk({31'h0, cv}, 32'h1);
      chk({16'h0, cd}, {16'h0, d[15:0]});
      rdc(CMD_CODE_ADDR, {16'h0, d[15:0]});
      rdc(CMD_WIN_BASE + 32'(i), 32'h0);
    end
    $display("test done: command window");
    for (int i = 0; i < 8; i++) begin
      a = OPT_BASE + {25'h0, 7'(rnd()) & 7'h7c};
      if (i == 7) a = OPT_LAST - 32'h3;
      d = rnd();
      acc(1'b1, a, d, SZ32);
      rdc(a, d);
    end
    acc(1'b1, OPT_LAST, 32'h5a, SZ8);
    rdc(OPT_LAST - 32'h3, {8'h5a, d[23:0]});
    acc(1'b1, OPT_LAST + 32'h1, rnd(), SZ32);
    rdc(OPT_LAST + 32'h1, 32'h0);
    $display("test done: option area");
    for (int j = 0; j < 2; j++) begin
      @(negedge mclk_i);
      if (j == 0) pulse(code_area_violation_flag_i);
      else pulse(data_area_violation_flag_i);
      chk({31'h0, command_lock_flag_o}, 32'h1);
      acc(1'b1, CMD_WIN_BASE, {16'(rnd()), 16'h0011}, SZ16);
      chk({31'h0, cv}, 32'h0);
      rdc(ACC_STAT_ADDR, j == 0 ? 32'h90 : 32'h18);
      // Data flag cleared by writing zero after it was read as one
      if (j == 1) acc(1'b1, ACC_STAT_ADDR, 32'h0, SZ8);
      rdc(ACC_STAT_ADDR, j == 0 ? 32'h90 : 32'h10);
      d = {24'h0, j == 0 ? STATUS_CLEAR_CODE : FORCED_STOP_CODE};
      acc(1'b1, CMD_WIN_BASE, d, SZ16);
      chk({31'h0, cv}, 32'h1);
      @(negedge mclk_i);
      chk({31'h0, command_lock_flag_o}, 32'h0);
      rdc(ACC_STAT_ADDR, 32'h0);
    end
    $display("test done: command lock");
    for (int e = 1; e >= 0; e--) begin
      acc(1'b1, RDY_IE_ADDR, 32'(e), SZ8);
      @(negedge mclk_i);
      pulse(fcu_done_i);
      chk({31'h0, ready_interrupt_o}, 32'(e));
      @(negedge mclk_i);
      chk({31'h0, ready_interrupt_o}, 32'h0);
    end
    $display("test done: ready interrupt");
    stop_test();
  end
endmodule : flash_program_erase_sequencer_front_tb

// [flash_seq_pkg.sv]
// Shared constants and types for the flash sequencer front end
package flash_seq_pkg;

  // ------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------
  localparam logic [31:0] CMD_WIN_BASE = 32'h007e_0000;
  localparam logic [31:0] CMD_WIN_LAST = 32'h007e_0003;
  localparam logic [31:0] OPT_BASE = 32'hfe7f_5d00;
  localparam logic [31:0] OPT_LAST = 32'hfe7f_5d7f;
  localparam int OPT_WORDS = 32;
  localparam logic [23:0] REG_PAGE = 24'h007f_e0;

  localparam logic [31:0] PROT_ADDR = 32'h0008_c296;
  localparam logic [31:0] ACC_STAT_ADDR = 32'h007f_e010;
  localparam logic [31:0] ERR_IE_ADDR = 32'h007f_e014;
  localparam logic [31:0] RDY_IE_ADDR = 32'h007f_e018;
  localparam logic [31:0] START_ADDR_ADDR = 32'h007f_e030;
  localparam logic [31:0] END_ADDR_ADDR = 32'h007f_e034;
  localparam logic [31:0] SEQ_STAT_ADDR = 32'h007f_e080;
  localparam logic [31:0] ENTRY_ADDR = 32'h007f_e084;
  localparam logic [31:0] SUINIT_ADDR = 32'h007f_e08c;
  localparam logic [31:0] CMD_CODE_ADDR = 32'h007f_e0a0;
  localparam logic [31:0] BC_CTRL_ADDR = 32'h007f_e0d0;
  localparam logic [31:0] BC_RES_ADDR = 32'h007f_e0d4;
  localparam logic [31:0] PSADDR_ADDR = 32'h007f_e0d8;
  localparam logic [31:0] WIN_MON_ADDR = 32'h007f_e0dc;
  localparam logic [31:0] PSW_ADDR = 32'h007f_e0e0;
  localparam logic [31:0] PCK_ADDR = 32'h007f_e0e4;
  localparam logic [31:0] SUACR_ADDR = 32'h007f_e0e8;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] PE_ENABLE_CODE = 2'b01;
  localparam logic [1:0] PROT_RST = 2'b00;
  localparam int CODE_AREA_VIOLATION_FLAG_BIT = 7;
  localparam int LOCK_BIT = 4;
  localparam int DATA_AREA_VIOLATION_FLAG_BIT = 3;
  localparam int RDY_IE_BIT = 0;
  localparam logic [7:0] ERR_IE_MASK = 8'h98;
  localparam logic [7:0] STATUS_CLEAR_CODE = 8'h5c;
  localparam logic [7:0] FORCED_STOP_CODE = 8'hc5;

  // ------------------------------------------------------------
  // Access timing, in cycles of mclk_i
  // ------------------------------------------------------------
  localparam logic [3:0] REG_ACC_CYC = 4'h2;
  localparam logic [3:0] PROT_ACC_CYC = 4'h4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ8 = 2'b00,
    SZ16 = 2'b01,
    SZ32 = 2'b10
  } size_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_DONE = 2'b11
  } phase_t;

  typedef struct packed {
    logic we;
    size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    phase_t ph;
    logic [3:0] cnt;
    bus_req_t req;
    logic [31:0] rdata;
    logic [1:0] prot;
    logic code_area_violation_flag;
    logic data_area_violation_flag;
    logic lock;
    logic cf_seen;
    logic df_seen;
    logic [7:0] err_ie;
    logic rdy_ie;
    logic [31:0] saddr;
    logic [31:0] eaddr;
    logic [15:0] entry;
    logic [15:0] suinit;
    logic [15:0] cmd_last;
    logic [7:0] bccnt;
    logic [15:0] cpsr;
    logic [15:0] pckar;
    logic [15:0] suacr;
    logic cmd_v;
    logic [15:0] cmd_d;
    logic rdy_irq;
    logic [OPT_WORDS-1:0][31:0] opt;
  } seq_state_t;

endpackage : flash_seq_pkg
